/* mii_path_regs.vh */
`ifndef MII_PATH_REGS_VH
`define MII_PATH_REGS_VH

// Register offsets (byte addresses)
`define BASIC_CTRL_OFFSET    8'h00
`define SPECIAL_CTRL_OFFSET  8'h04
`define PATH_STATUS_OFFSET   8'h08

// Basic control fields
`define BC_ISOLATE           0
`define BC_EXT_LOOPBACK      1
`define BC_EXT_COL_TEST      2
`define BC_SPEED_LOW         3
`define BC_FULL_DUPLEX       4
`define BASIC_CTRL_RESET     5'h00

// Special control fields
`define SC_TURBO             0
`define SC_HB_DISABLE        1
`define SC_SW_COL_TEST       2
`define SC_SW_LOOPBACK       3
`define SC_REFCLK_DIR        4
`define SPECIAL_CTRL_RESET   5'h00

// Operating modes
`define MODE_INT_PHY         3'h0
`define MODE_MII_MAC         3'h1
`define MODE_RMII_MAC        3'h2
`define MODE_MII_PHY         3'h3
`define MODE_RMII_PHY        3'h4

// Timing, clock 100 ns
`define PCLK_PERIOD_NS       100
`define HB_DELAY_NS          1000
`define HB_DELAY_MIN_NS      600
`define HB_DELAY_MAX_NS      1600
`define HB_WIDTH_NS          1000
`define HB_WIDTH_MIN_NS      500
`define HB_WIDTH_MAX_NS      1500
`define HB_DELAY_CYC         (`HB_DELAY_NS / `PCLK_PERIOD_NS)
`define HB_WIDTH_CYC         (`HB_WIDTH_NS / `PCLK_PERIOD_NS)

`endif

/* heartbeat_timer.v */
`timescale 1ns/10ps
`include "mii_path_regs.vh"

// Delays a pulse after an end of an external transmission that falls while idle; ends during wait or pulse are ignored
module heartbeat_timer #(
	parameter DELAY_CYC = `HB_DELAY_CYC,
	parameter WIDTH_CYC = `HB_WIDTH_CYC
) (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       enable,
	input  wire       tx_valid,
	output reg        heartbeat_pulse
);
	localparam [2:0] ST_IDLE  = 3'h1;
	localparam [2:0] ST_WAIT  = 3'h2;
	localparam [2:0] ST_PULSE = 3'h4;

	reg [2:0] state;
	reg [7:0] count;
	reg       valid_prev;

	// Falling edge of transmit valid starts the wait; disable aborts at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state           <= ST_IDLE;
			count           <= 8'h00;
			valid_prev      <= 1'b0;
			heartbeat_pulse <= 1'b0;
		end else begin
			valid_prev <= tx_valid;
			if (!enable) begin
				state           <= ST_IDLE;
				heartbeat_pulse <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: begin
					if (valid_prev && !tx_valid) begin
						state <= ST_WAIT;
						count <= DELAY_CYC[7:0] - 8'h01;
					end
				end
				ST_WAIT: begin
					if (count == 8'h00) begin
						state           <= ST_PULSE;
						count           <= WIDTH_CYC[7:0] - 8'h01;
						heartbeat_pulse <= 1'b1;
					end else begin
						count <= count - 8'h01;
					end
				end
				ST_PULSE: begin
					if (count == 8'h00) begin
						state           <= ST_IDLE;
						heartbeat_pulse <= 1'b0;
					end else begin
						count <= count - 8'h01;
					end
				end
				default: begin
					state           <= ST_IDLE;
					heartbeat_pulse <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule // heartbeat_timer

/* switch_port_mii_datapath.v */
`timescale 1ns/10ps
`include "mii_path_regs.vh"

module switch_port_mii_datapath #(
	parameter HALF_10  = 4,
	parameter HALF_100 = 2,
	parameter HALF_200 = 1
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [2:0]  mode_select,
	input  wire [3:0]  fab_txd,
	input  wire        fab_tx_en,
	input  wire        fab_tx_er,
	output reg  [3:0]  fab_rxd,
	output reg         fab_rx_dv,
	output reg         fab_rx_er,
	output reg         fab_col,
	output reg         fab_crs,
	output reg         fab_clk,
	output reg         fab_full_duplex,
	output reg  [3:0]  phy_txd,
	output reg         phy_tx_en,
	output reg         phy_tx_er,
	input  wire [3:0]  phy_rxd,
	input  wire        phy_rx_dv,
	input  wire        phy_rx_er,
	input  wire        phy_col,
	input  wire        phy_crs,
	input  wire        phy_duplex,
	output reg  [3:0]  port1_tx_data_pins,
	output reg  [3:0]  port1_tx_data_oe_n,
	output reg         port1_tx_valid_pin,
	output reg         port1_tx_error_pin,
	output reg         port1_tx_ctl_oe_n,
	input  wire [3:0]  port1_rx_data_pins,
	input  wire        port1_rx_valid_pin,
	input  wire        port1_rx_error_pin,
	input  wire        port1_collision_in,
	output reg         port1_collision_out,
	input  wire        port1_carrier_in,
	output reg         port1_carrier_out,
	input  wire        port1_tx_clock_in,
	output reg         port1_tx_clock_out,
	input  wire        port1_rx_clock_in,
	output reg         port1_rx_clock_out,
	output reg         port1_phy_pins_oe_n,
	input  wire        port1_reference_clock_in,
	output wire        port1_reference_clock_out,
	output wire        port1_reference_clock_oe_n,
	input  wire        internal_ref_clock,
	output wire        rmii_ref_clock,
	output reg         pull_enable
);
	reg  [2:0]  mode;
	reg         mode_taken;
	reg  [4:0]  basic_ctrl;
	reg  [4:0]  special_ctrl;
	reg  [9:0]  sync1;
	reg  [9:0]  sync2;
	reg  [7:0]  div_count;
	reg         div_clk;
	reg         ext_seen;
	wire        hb_pulse;

	// Pin inputs pass two flops; only sync2 is read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 10'h000;
			sync2 <= 10'h000;
		end else begin
			sync1 <= {port1_rx_clock_in, port1_tx_clock_in, port1_carrier_in,
				port1_collision_in, port1_rx_error_pin, port1_rx_valid_pin,
				port1_rx_data_pins};
			sync2 <= sync1;
		end
	end

	// Mode is a strap, caught once after reset release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode       <= `MODE_INT_PHY;
			mode_taken <= 1'b0;
		end else if (!mode_taken) begin
			mode       <= mode_select;
			mode_taken <= 1'b1;
		end
	end

	wire is_int     = (mode == `MODE_INT_PHY);
	wire is_mii_mac = (mode == `MODE_MII_MAC);
	wire is_rmii_mc = (mode == `MODE_RMII_MAC);
	wire is_mii_phy = (mode == `MODE_MII_PHY);
	wire is_rmii_ph = (mode == `MODE_RMII_PHY);
	wire is_phy     = is_mii_phy | is_rmii_ph;
	wire is_rmii    = is_rmii_mc | is_rmii_ph;
	wire is_pins    = is_mii_mac | is_rmii_mc | is_phy;

	wire isolate    = basic_ctrl[`BC_ISOLATE] & is_phy;
	wire ext_lb     = basic_ctrl[`BC_EXT_LOOPBACK] & is_phy;
	wire ext_ct     = basic_ctrl[`BC_EXT_COL_TEST] & is_mii_phy;
	wire speed_low  = basic_ctrl[`BC_SPEED_LOW];
	wire full_dup   = basic_ctrl[`BC_FULL_DUPLEX];
	wire turbo      = special_ctrl[`SC_TURBO];
	wire sw_ct      = special_ctrl[`SC_SW_COL_TEST] & is_phy;
	wire sw_lb      = special_ctrl[`SC_SW_LOOPBACK] & is_phy;
	wire ref_dir    = special_ctrl[`SC_REFCLK_DIR];

	// Isolated inputs fall to the inactive state
	wire [3:0] rmii_mask = is_rmii ? 4'h3 : 4'hF;
	wire [3:0] ext_txd   = isolate ? 4'h0 : (sync2[3:0] & rmii_mask);
	wire       ext_tx_en = isolate ? 1'b0 : sync2[4];
	wire       ext_tx_er = isolate | is_rmii ? 1'b0 : sync2[5];
	wire       pin_col   = sync2[6];
	wire       pin_crs   = sync2[7];
	wire       pin_txclk = sync2[8];
	wire       pin_rxclk = sync2[9];

	// Rate select: turbo swaps 100 Mbps for 200 Mbps
	wire       rate_10   = !speed_low;
	wire [7:0] half_per  = rate_10 ? HALF_10[7:0] :
		(turbo ? HALF_200[7:0] : HALF_100[7:0]);

	// Clock generator for PHY modes; pclk bounds the true rate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_count <= 8'h00;
			div_clk   <= 1'b0;
		end else if (div_count + 8'h01 >= half_per) begin
			div_count <= 8'h00;
			div_clk   <= ~div_clk;
		end else begin
			div_count <= div_count + 8'h01;
		end
	end

	// Heartbeat only in 10 Mbit half duplex MII PHY, not in external loopback
	wire hb_enable = is_mii_phy & rate_10 & !full_dup & !ext_lb & !isolate &
		!special_ctrl[`SC_HB_DISABLE];

	heartbeat_timer #(
		.DELAY_CYC (`HB_DELAY_CYC),
		.WIDTH_CYC (`HB_WIDTH_CYC)
	) u_heartbeat (
		.pclk            (pclk),
		.presetn         (presetn),
		.enable          (hb_enable),
		.tx_valid        (ext_tx_en),
		.heartbeat_pulse (hb_pulse)
	);

	// Fabric receive side in PHY modes
	wire [3:0] phy_fab_rxd = sw_lb ? (fab_txd & rmii_mask) : (ext_lb ? 4'h0 : ext_txd);
	wire       phy_fab_dv  = sw_lb ? fab_tx_en : (ext_lb ? 1'b0 : ext_tx_en);
	wire       phy_fab_er  = sw_lb ? fab_tx_er & !is_rmii : (ext_lb ? 1'b0 : ext_tx_er);
	wire       fab_in_tx   = !ext_lb & fab_tx_en;
	wire       ext_in_tx   = !sw_lb & ext_tx_en;
	wire       phy_fab_crs = sw_lb ? fab_tx_en : (fab_in_tx | ext_in_tx);
	wire       phy_fab_col = (sw_ct & fab_tx_en) |
		(!sw_lb & !ext_lb & !full_dup & fab_tx_en & ext_tx_en);

	// Pin transmit side in PHY modes
	wire [3:0] phy_pin_txd = ext_lb ? ext_txd : (sw_lb ? 4'h0 : (fab_txd & rmii_mask));
	wire       phy_pin_dv  = ext_lb ? ext_tx_en : (sw_lb ? 1'b0 : fab_tx_en);
	wire       phy_pin_er  = ext_lb ? ext_tx_er : (sw_lb ? 1'b0 : fab_tx_er & !is_rmii);
	wire       phy_pin_crs = ext_lb ? ext_tx_en : (fab_in_tx & !sw_lb) | ext_tx_en;
	wire       phy_pin_col = (ext_ct & ext_tx_en) | hb_pulse |
		(!sw_lb & !ext_lb & !full_dup & fab_tx_en & ext_tx_en);

	// Next values of the fabric outputs
	reg [3:0] next_fab_rxd;
	reg       next_fab_rx_dv;
	reg       next_fab_rx_er;
	reg       next_fab_col;
	reg       next_fab_crs;
	reg       next_fab_clk;
	reg       next_fab_dup;
	always @* begin
		next_fab_rxd   = 4'h0;
		next_fab_rx_dv = 1'b0;
		next_fab_rx_er = 1'b0;
		next_fab_col   = 1'b0;
		next_fab_crs   = 1'b0;
		next_fab_clk   = div_clk;
		next_fab_dup   = full_dup;
		if (is_int) begin
			next_fab_rxd   = phy_rxd;
			next_fab_rx_dv = phy_rx_dv;
			next_fab_rx_er = phy_rx_er;
			next_fab_col   = phy_col;
			next_fab_crs   = phy_crs;
			next_fab_dup   = phy_duplex;
		end else if (is_mii_mac) begin
			next_fab_rxd   = sync2[3:0];
			next_fab_rx_dv = sync2[4];
			next_fab_rx_er = sync2[5];
			next_fab_col   = pin_col;
			next_fab_crs   = pin_crs;
			next_fab_clk   = pin_rxclk;
		end else if (is_rmii_mc) begin
			next_fab_rxd   = sync2[3:0] & rmii_mask;
			next_fab_rx_dv = sync2[4];
			next_fab_crs   = sync2[4];
		end else if (is_phy) begin
			next_fab_rxd   = phy_fab_rxd;
			next_fab_rx_dv = phy_fab_dv;
			next_fab_rx_er = phy_fab_er;
			next_fab_col   = phy_fab_col;
			next_fab_crs   = phy_fab_crs;
		end
	end

	// Next values of the pins and their enables
	reg [3:0] next_txd;
	reg [3:0] next_txd_oe_n;
	reg       next_tx_dv;
	reg       next_tx_er;
	reg       next_ctl_oe_n;
	reg       next_col;
	reg       next_crs;
	reg       next_phy_oe_n;
	always @* begin
		next_txd      = fab_txd & rmii_mask;
		next_tx_dv    = fab_tx_en;
		next_tx_er    = fab_tx_er & !is_rmii;
		next_txd_oe_n = ~rmii_mask;
		next_ctl_oe_n = 1'b0;
		next_col      = 1'b0;
		next_crs      = 1'b0;
		next_phy_oe_n = 1'b1;
		if (is_phy) begin
			next_txd   = phy_pin_txd;
			next_tx_dv = phy_pin_dv;
			next_tx_er = phy_pin_er;
			if (is_mii_phy) begin
				next_col      = phy_pin_col;
				next_crs      = phy_pin_crs;
				next_phy_oe_n = isolate;
			end
		end
		if (!is_pins || isolate) begin
			next_txd      = 4'h0;
			next_tx_dv    = 1'b0;
			next_tx_er    = 1'b0;
			next_txd_oe_n = 4'hF;
			next_ctl_oe_n = 1'b1;
		end
	end

	// All data outputs come from flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fab_rxd             <= 4'h0;
			fab_rx_dv           <= 1'b0;
			fab_rx_er           <= 1'b0;
			fab_col             <= 1'b0;
			fab_crs             <= 1'b0;
			fab_clk             <= 1'b0;
			fab_full_duplex     <= 1'b0;
			phy_txd             <= 4'h0;
			phy_tx_en           <= 1'b0;
			phy_tx_er           <= 1'b0;
			port1_tx_data_pins  <= 4'h0;
			port1_tx_data_oe_n  <= 4'hF;
			port1_tx_valid_pin  <= 1'b0;
			port1_tx_error_pin  <= 1'b0;
			port1_tx_ctl_oe_n   <= 1'b1;
			port1_collision_out <= 1'b0;
			port1_carrier_out   <= 1'b0;
			port1_tx_clock_out  <= 1'b0;
			port1_rx_clock_out  <= 1'b0;
			port1_phy_pins_oe_n <= 1'b1;
			pull_enable         <= 1'b1;
		end else begin
			fab_rxd             <= next_fab_rxd;
			fab_rx_dv           <= next_fab_rx_dv;
			fab_rx_er           <= next_fab_rx_er;
			fab_col             <= next_fab_col;
			fab_crs             <= next_fab_crs;
			fab_clk             <= next_fab_clk;
			fab_full_duplex     <= next_fab_dup;
			phy_txd             <= is_int ? fab_txd : 4'h0;
			phy_tx_en           <= is_int & fab_tx_en;
			phy_tx_er           <= is_int & fab_tx_er;
			port1_tx_data_pins  <= next_txd;
			port1_tx_data_oe_n  <= next_txd_oe_n;
			port1_tx_valid_pin  <= next_tx_dv;
			port1_tx_error_pin  <= next_tx_er;
			port1_tx_ctl_oe_n   <= next_ctl_oe_n;
			port1_collision_out <= next_col;
			port1_carrier_out   <= next_crs;
			port1_tx_clock_out  <= is_mii_phy & div_clk;
			port1_rx_clock_out  <= is_mii_phy & div_clk;
			port1_phy_pins_oe_n <= next_phy_oe_n;
			pull_enable         <= !isolate;
		end
	end

	// Reference clock: a plain mux, so change direction only while idle
	wire ref_drive = is_rmii & ref_dir & !isolate;
	assign rmii_ref_clock             = ref_dir ? internal_ref_clock
		: port1_reference_clock_in;
	assign port1_reference_clock_out = ref_drive ? internal_ref_clock : 1'b0;
	assign port1_reference_clock_oe_n = !ref_drive;

	// Sticky record of external traffic, cleared by writing status
	wire wr_en  = psel & penable & pwrite;
	wire st_clr = wr_en && (paddr == `PATH_STATUS_OFFSET) && pwdata[4];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_seen <= 1'b0;
		end else if (ext_tx_en) begin
			ext_seen <= 1'b1; // Set wins over clear
		end else if (st_clr) begin
			ext_seen <= 1'b0;
		end
	end

	// APB slave: zero wait states, unmapped addresses flag an error
	function mapped;
		input [7:0] addr;
		begin
			mapped = (addr == `BASIC_CTRL_OFFSET) || (addr == `SPECIAL_CTRL_OFFSET) ||
				(addr == `PATH_STATUS_OFFSET);
		end
	endfunction

	assign pready  = 1'b1;
	assign pslverr = psel & penable & !mapped(paddr);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			basic_ctrl   <= `BASIC_CTRL_RESET;
			special_ctrl <= `SPECIAL_CTRL_RESET;
			prdata       <= 32'h00000000;
		end else begin
			if (wr_en && paddr == `BASIC_CTRL_OFFSET)
				basic_ctrl <= pwdata[4:0];
			if (wr_en && paddr == `SPECIAL_CTRL_OFFSET)
				special_ctrl <= pwdata[4:0];
			if (psel && !penable) begin
				case (paddr)
				`BASIC_CTRL_OFFSET:   prdata <= {27'h0000000, basic_ctrl};
				`SPECIAL_CTRL_OFFSET: prdata <= {27'h0000000, special_ctrl};
				`PATH_STATUS_OFFSET:  prdata <= {26'h0000000, fab_full_duplex,
					ext_seen, hb_pulse, mode};
				default:              prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // switch_port_mii_datapath

/* switch_port_mii_datapath_asserts.sv */
`timescale 1ns/10ps
`include "mii_path_regs.vh"

// Watches the top ports only; the strap is steady outside reset
module switch_port_mii_datapath_asserts (
	input wire       pclk,
	input wire       presetn,
	input wire [2:0] mode_select,
	input wire [3:0] fab_txd,
	input wire       fab_tx_en,
	input wire       fab_tx_er,
	input wire [3:0] phy_txd,
	input wire       phy_tx_en,
	input wire       phy_duplex,
	input wire       fab_full_duplex,
	input wire [3:0] port1_tx_data_pins,
	input wire [3:0] port1_tx_data_oe_n,
	input wire       port1_tx_valid_pin,
	input wire       port1_tx_error_pin,
	input wire       port1_tx_ctl_oe_n,
	input wire       port1_collision_out,
	input wire       port1_phy_pins_oe_n,
	input wire       port1_reference_clock_out,
	input wire       port1_reference_clock_oe_n,
	input wire       internal_ref_clock,
	input wire       rmii_ref_clock,
	input wire       pull_enable
);
	logic [1:0] up;
	wire        st = (up == 2'h3);
	wire [2:0]  md = mode_select;

	// Settle count, so the strap and the output flops are past their first edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up <= 2'h0;
		else if (!st)
			up <= up + 2'h1;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_mac_tx;
		st && md == `MODE_MII_MAC |-> port1_tx_data_pins == $past(fab_txd)
			&& port1_tx_valid_pin == $past(fab_tx_en) && port1_tx_error_pin == $past(fab_tx_er);
	endproperty
	a_mac_tx: assert property (p_mac_tx) else $error("tx pins lag fabric");

	property p_mac_dir;
		st && md == `MODE_MII_MAC |-> port1_phy_pins_oe_n && !port1_tx_ctl_oe_n && pull_enable;
	endproperty
	a_mac_dir: assert property (p_mac_dir) else $error("mac mode pin direction");

	property p_phy_iso;
		st && md == `MODE_MII_PHY |-> port1_phy_pins_oe_n != pull_enable;
	endproperty
	a_phy_iso: assert property (p_phy_iso) else $error("isolate pulls and enables");

	property p_int_tx;
		st && md == `MODE_INT_PHY |-> phy_txd == $past(fab_txd) && phy_tx_en == $past(fab_tx_en)
			&& fab_full_duplex == $past(phy_duplex);
	endproperty
	a_int_tx: assert property (p_int_tx) else $error("internal phy routing");

	property p_int_off;
		st && md != `MODE_INT_PHY |-> !phy_tx_en && phy_txd == 4'h0;
	endproperty
	a_int_off: assert property (p_int_off) else $error("internal phy fed off mode");

	property p_rmii_w;
		st && (md == `MODE_RMII_PHY || md == `MODE_RMII_MAC)
			|-> port1_tx_data_oe_n[3:2] == 2'h3 && port1_tx_data_pins[3:2] == 2'h0;
	endproperty
	a_rmii_w: assert property (p_rmii_w) else $error("rmii upper bits in use");

	property p_ref_out;
		!port1_reference_clock_oe_n |-> rmii_ref_clock == internal_ref_clock
			&& port1_reference_clock_out == internal_ref_clock;
	endproperty
	a_ref_out: assert property (p_ref_out) else $error("ref clock source");

	property p_rmii_col;
		st && md == `MODE_RMII_PHY |-> !port1_collision_out [*2];
	endproperty
	a_rmii_col: assert property (p_rmii_col) else $error("heartbeat in rmii");
endmodule // switch_port_mii_datapath_asserts

/* ext_end.sv */
`timescale 1ns/10ps

// Far end of port 1: external MAC in PHY modes, external PHY in MAC modes
module ext_end (
	output logic [3:0] port1_rx_data_pins,
	output logic       port1_rx_valid_pin,
	output logic       port1_rx_error_pin,
	output wire        port1_collision_in,
	output wire        port1_carrier_in,
	output wire        port1_tx_clock_in,
	output wire        port1_rx_clock_in,
	output wire        port1_reference_clock_in,
	input  wire        port1_phy_pins_oe_n,
	input  wire        port1_collision_out,
	input  wire        port1_carrier_out,
	input  wire        port1_tx_clock_out,
	input  wire        port1_rx_clock_out,
	input  wire        port1_reference_clock_out,
	input  wire        port1_reference_clock_oe_n
);
	logic lclk = 1'b0;
	logic rclk = 1'b1;

	// Own 50 MHz reference, seen only while the device leaves the pin
	// Opposite in phase to the internal one, so a wrong source shows
	always #10 rclk = ~rclk;

	initial begin
		port1_rx_data_pins = 4'h0;
		port1_rx_valid_pin = 1'b0;
		port1_rx_error_pin = 1'b0;
	end

	// Shared pins resolve to whoever has the drive
	assign port1_collision_in = port1_phy_pins_oe_n ? 1'b0 : port1_collision_out;
	assign port1_carrier_in = port1_phy_pins_oe_n ? port1_rx_valid_pin : port1_carrier_out;
	assign port1_tx_clock_in = port1_phy_pins_oe_n ? lclk : port1_tx_clock_out;
	assign port1_rx_clock_in = port1_phy_pins_oe_n ? lclk : port1_rx_clock_out;
	assign port1_reference_clock_in = port1_reference_clock_oe_n ? rclk : port1_reference_clock_out;

	// Frame of n link cycles; clock stands still between frames
	task frame(input logic [3:0] d, input int n);
		repeat (n) begin
			port1_rx_data_pins = d;
			port1_rx_valid_pin = 1'b1;
			lclk = 1'b0;
			#400 lclk = 1'b1;
			#400;
		end
		lclk = 1'b0;
		port1_rx_valid_pin = 1'b0;
		port1_rx_data_pins = ~d; // Stale data must not look valid
	endtask
endmodule // ext_end

/* switch_port_mii_datapath_bench.sv */
`timescale 1ns/10ps
`include "mii_path_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module switch_port_mii_datapath_bench;
	localparam H10 = 4, H100 = 2, H200 = 1;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        fab_tx_en = 0, fab_tx_er = 0, phy_rx_dv = 0, phy_rx_er = 0, phy_col = 0;
	logic        phy_crs = 0, phy_duplex = 0, internal_ref_clock = 0, serr, p, q;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, rdata;
	logic [2:0]  mode_select = 0;
	logic [3:0]  fab_txd = 0, phy_rxd = 0;
	wire  [31:0] prdata;
	wire  [3:0]  fab_rxd, phy_txd, port1_tx_data_pins, port1_tx_data_oe_n, port1_rx_data_pins;
	wire         pready, pslverr, fab_rx_dv, fab_rx_er, fab_col, fab_crs, fab_clk;
	wire         fab_full_duplex, phy_tx_en, phy_tx_er, port1_tx_valid_pin, port1_tx_error_pin;
	wire         port1_tx_ctl_oe_n, port1_rx_valid_pin, port1_rx_error_pin, port1_collision_in;
	wire         port1_collision_out, port1_carrier_in, port1_carrier_out, port1_tx_clock_in;
	wire         port1_tx_clock_out, port1_rx_clock_in, port1_rx_clock_out, port1_phy_pins_oe_n;
	wire         port1_reference_clock_in, port1_reference_clock_out, port1_reference_clock_oe_n;
	wire         rmii_ref_clock, pull_enable;
	int          err_count = 0, checks = 0, cycles = 0, i, n;

	// 10 MHz bus clock, 50 MHz internal reference
	always #50 pclk = ~pclk;
	always #10 internal_ref_clock = ~internal_ref_clock;

	switch_port_mii_datapath #(.HALF_10(H10), .HALF_100(H100), .HALF_200(H200))
		i_switch_port_mii_datapath (.*);
	ext_end i_ext_end (.*);

	task cyc(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask

	task fab(input logic en, input logic er, input logic [3:0] d);
		@(posedge pclk);
		fab_tx_en <= en;
		fab_tx_er <= er;
		fab_txd <= d;
	endtask

	// Strap is only caught on the first edge after release
	task rst(input logic [2:0] m);
		@(posedge pclk);
		presetn <= 1'b0;
		mode_select <= m;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		cyc(1);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task t_regs;
		rst(`MODE_MII_PHY);
		apb(0, `BASIC_CTRL_OFFSET, 0);
		`CHK(rdata, 32'h0)
		apb(1, `SPECIAL_CTRL_OFFSET, 32'hFFFFFFFF);
		apb(0, `SPECIAL_CTRL_OFFSET, 0);
		`CHK(rdata, 32'h1F)
		apb(0, 8'h0C, 0);
		`CHK({serr, rdata}, 33'h100000000)
		apb(0, `PATH_STATUS_OFFSET, 0);
		`CHK(rdata[2:0], `MODE_MII_PHY)
	endtask

	task t_mac;
		rst(`MODE_MII_MAC);
		fab(1, 1, 4'hA);
		cyc(1);
		`CHK({port1_tx_valid_pin, port1_tx_error_pin, port1_tx_data_pins}, 6'h3A)
		fork
			i_ext_end.frame(4'h6, 4);
			begin
				cyc(12);
				`CHK({fab_crs, fab_rx_dv, fab_rxd}, 6'h36)
				// Far clock toggles every 4 cycles inside a frame
				n = 0;
				for (i = 0; i < 16; i++) begin
					p = fab_clk;
					cyc(1);
					if (p !== fab_clk)
						n++;
				end
				`CHK(n, 4)
			end
		join
		fab(0, 0, 4'h0);
	endtask

	// Toggles of both link clocks in 16 cycles give the half period
	task rate(input logic [31:0] b, input logic [31:0] s, input int h);
		apb(1, `BASIC_CTRL_OFFSET, b);
		apb(1, `SPECIAL_CTRL_OFFSET, s);
		cyc(8);
		n = 0;
		for (i = 0; i < 16; i++) begin
			p = port1_rx_clock_out;
			q = port1_tx_clock_out;
			cyc(1);
			if (p !== port1_rx_clock_out)
				n++;
			if (q !== port1_tx_clock_out)
				n++;
		end
		`CHK(n, 32 / h)
	endtask

	task t_hb;
		rst(`MODE_MII_PHY);
		fork
			i_ext_end.frame(4'h3, 2);
			begin cyc(10); `CHK(port1_carrier_out, 1'b1) end
		join
		for (n = 0; n < 40 && port1_collision_out !== 1'b1; n++) cyc(1);
		`CHK(n >= 6 && n <= 16, 1'b1)
		for (n = 0; n < 40 && port1_collision_out === 1'b1; n++) cyc(1);
		`CHK(n >= 5 && n <= 15, 1'b1)
		// Sticky traffic flag reads set, then a write of one clears it
		apb(0, `PATH_STATUS_OFFSET, 0);
		`CHK(rdata, 32'h13)
		apb(1, `PATH_STATUS_OFFSET, 32'h10);
		apb(0, `PATH_STATUS_OFFSET, 0);
		`CHK(rdata, 32'h3)
		apb(1, `SPECIAL_CTRL_OFFSET, 32'h2);
		cyc(2);
		i_ext_end.frame(4'h3, 2);
		for (n = 0; n < 30 && port1_collision_out !== 1'b1; n++) cyc(1);
		`CHK(n, 30)
		rate(32'h8, 32'h0, H100);
		rate(32'h8, 32'h1, H200);
		rate(32'h0, 32'h1, H10);
	endtask

	task t_iso;
		rst(`MODE_MII_PHY);
		apb(1, `BASIC_CTRL_OFFSET, 32'h1);
		cyc(2);
		`CHK({port1_phy_pins_oe_n, port1_tx_ctl_oe_n, pull_enable}, 3'b110)
		fork
			i_ext_end.frame(4'h9, 3);
			begin cyc(12); `CHK(fab_rx_dv, 1'b0) end
		join
		apb(1, `SPECIAL_CTRL_OFFSET, 32'hC);
		fab(1, 0, 4'h5);
		cyc(4);
		`CHK({fab_col, fab_rx_dv, fab_rxd}, 6'h35)
		apb(1, `BASIC_CTRL_OFFSET, 32'h0);
		cyc(3);
		`CHK(port1_tx_valid_pin, 1'b0)
		fab(0, 0, 4'h0);
	endtask

	task t_rmii;
		rst(`MODE_RMII_PHY);
		`CHK(rmii_ref_clock, i_ext_end.rclk)
		apb(1, `BASIC_CTRL_OFFSET, 32'h6);
		cyc(1);
		fork
			i_ext_end.frame(4'hF, 4);
			begin cyc(12); `CHK({port1_tx_valid_pin, port1_tx_data_pins, fab_rx_dv,
				port1_collision_out}, 7'h4C) end
		join
		fab(1, 0, 4'hC);
		cyc(6);
		`CHK(port1_tx_valid_pin, 1'b0)
		fab(0, 0, 4'h0);
		apb(1, `SPECIAL_CTRL_OFFSET, 32'h10);
		cyc(2);
		`CHK({port1_reference_clock_oe_n, rmii_ref_clock}, {1'b0, internal_ref_clock})
		apb(1, `BASIC_CTRL_OFFSET, 32'h1);
		cyc(2);
		`CHK({port1_reference_clock_oe_n, port1_tx_ctl_oe_n, pull_enable}, 3'b110)
	endtask

	task t_int;
		rst(`MODE_INT_PHY);
		@(posedge pclk);
		phy_duplex <= 1'b1;
		phy_rx_dv <= 1'b1;
		phy_rx_er <= 1'b1;
		phy_rxd <= 4'hC;
		fab(1, 1, 4'h7);
		cyc(3);
		`CHK({fab_full_duplex, fab_rx_dv, fab_rx_er, fab_rxd}, 7'h7C)
		`CHK({phy_tx_en, phy_tx_er, phy_txd}, 6'h37)
	endtask

	// RMII MAC: two bits each way, isolate has no effect
	task t_rmac;
		rst(`MODE_RMII_MAC);
		fab(1, 0, 4'hF);
		cyc(1);
		`CHK({port1_tx_valid_pin, port1_tx_data_pins, port1_tx_data_oe_n}, 9'h13C)
		fork
			i_ext_end.frame(4'hE, 2);
			begin cyc(10); `CHK({fab_crs, fab_rx_dv, fab_rxd}, 6'h32) end
		join
		apb(1, `BASIC_CTRL_OFFSET, 32'h1);
		cyc(2);
		`CHK({port1_tx_ctl_oe_n, pull_enable, rmii_ref_clock}, {2'b01, i_ext_end.rclk})
		fab(0, 0, 4'h0);
	endtask

	task stop_test;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test;
		end
	end

	initial begin
		t_regs;
		t_mac;
		t_hb;
		t_iso;
		t_rmii;
		t_int;
		t_rmac;
		stop_test;
	end
endmodule // switch_port_mii_datapath_bench

bind switch_port_mii_datapath switch_port_mii_datapath_asserts i_switch_port_mii_datapath_asserts (.*);
